// ===== hdl/fwg_top.sv
module fwg_top
    import fwg_pkg::*;
#(
    parameter int unsigned ERASE_CYCLES_P = ERASE_CYCLES // Erase cycles
) (
    input  wire logic        ref_clk,     // 50 MHz system clock
    input  wire logic        srst,        // Sync reset, active high
    input  wire logic        wb_cyc_i,    // Wishbone cycle
    input  wire logic        wb_stb_i,    // Wishbone strobe
    input  wire logic        wb_we_i,     // Wishbone write
    input  wire logic [3:0]  wb_adr_i,    // Byte address
    input  wire logic [3:0]  wb_sel_i,    // Byte selects
    input  wire logic [31:0] wb_dat_i,    // Write data
    output logic      [31:0] wb_dat_o,    // Read data
    output logic             wb_ack_o,    // Acknowledge
    input  fwg_store_t       st_i,        // Processor store
    output logic             st_ack_o,    // Store done pulse
    input  fwg_fetch_t       cd_i,        // Code-space read
    output logic             cd_ack_o,    // Code read done
    output logic      [7:0]  cd_data_o,   // Code read byte
    input  fwg_fetch_t       ld_i,        // Data load
    input  wire logic [15:0] exec_pc_i,   // Executing address
    output logic             stall_o,     // Hold processor
    output fwg_store_t       ram_wr_o,    // Data RAM write
    output fwg_fetch_t       ram_rd_o,    // Data RAM read
    output fwg_flash_cmd_t   fl_o,        // Flash array command
    input  wire logic [7:0]  fl_rdata_i,  // Flash read byte
    output logic             ferr_rst_o   // Flash error reset
);

    fwg_key_t         key_reg;
    fwg_seq_t         st_reg;
    logic             swe_reg;
    logic             see_reg;
    logic [7:0]       lock_reg;
    logic [7:0]       op_data_reg;
    logic             rd_ph_reg;
    logic             wb_hit;
    logic             wb_wr;
    logic             key_wr;
    logic             st_take;
    logic             cd_take;
    logic             flash_st;
    logic             bad_try;
    logic             st_ok;
    logic             cd_ok;
    logic             op_go;
    logic             sec_fail;
    logic             rd_last;
    logic             op_end;
    logic             tmr_start;
    logic [TMR_W-1:0] tmr_count;
    logic             tmr_busy;
    logic             tmr_done;
    logic [31:0]      rd_word;
    logic [1:0]       key_code;

    // Page locked by count; the lock page also by any cleared lock bit
    function automatic logic page_lock(
        input logic [4:0] pg,
        input logic [7:0] lb
    );
        page_lock = ({3'h0, pg} < ~lb) ||
                    ((lb != ERASED_BYTE) && (pg == LOCK_PAGE));
    endfunction

    // Access check against reserved area and lock pages
    function automatic logic access_ok(
        input logic [15:0] a,
        input logic        erase,
        input logic [15:0] pc,
        input logic [7:0]  lb
    );
        logic tgt;
        logic own;
        tgt = page_lock(a[PAGE_MSB:PAGE_LSB], lb);
        own = (pc <= USER_TOP) && page_lock(pc[PAGE_MSB:PAGE_LSB], lb);
        if (a > USER_TOP) begin
            access_ok = 1'b0;
        end else if (!tgt) begin
            access_ok = 1'b1;
        end else if (!own) begin
            access_ok = 1'b0;
        end else if (erase && (a[PAGE_MSB:PAGE_LSB] == LOCK_PAGE)) begin
            access_ok = 1'b0;
        end else begin
            access_ok = 1'b1;
        end
    endfunction

    // Bus decode
    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr  = wb_hit && wb_we_i && wb_sel_i[0];
    assign key_wr = wb_wr && (wb_adr_i == REG_KEY_OFS);

    // Request acceptance, stores before code reads
    assign st_take  = (st_reg == ST_IDLE) && st_i.req && !st_ack_o;
    assign cd_take  = (st_reg == ST_IDLE) && cd_i.req && !cd_ack_o &&
                      !st_take;
    assign flash_st = st_take && swe_reg;
    assign bad_try  = flash_st && (key_reg != KY_OPEN);
    assign st_ok    = access_ok(st_i.addr, see_reg, exec_pc_i, lock_reg);
    assign cd_ok    = access_ok(cd_i.addr, 1'b0, exec_pc_i, lock_reg);
    assign op_go    = flash_st && (key_reg == KY_OPEN) && st_ok;
    assign sec_fail = (flash_st && (key_reg == KY_OPEN) && !st_ok) ||
                      (cd_take && !cd_ok);

    // Second cycle of a flash read, and end of a timed operation
    assign rd_last = rd_ph_reg &&
                     ((st_reg == ST_BOOTW) || (st_reg == ST_CODE) ||
                      (st_reg == ST_PREAD));
    assign op_end  = tmr_done &&
                     ((st_reg == ST_PROG) || (st_reg == ST_ERASE));

    // Timer load: erase at acceptance, program after old byte read
    assign tmr_start = (op_go && see_reg) ||
                       (rd_last && (st_reg == ST_PREAD));
    assign tmr_count = (st_reg == ST_PREAD) ? TMR_W'(WRITE_CYCLES) :
                       TMR_W'(ERASE_CYCLES_P);

    fwg_cycle_timer #(
        .W       (TMR_W)
    ) u_timer (
        .ref_clk (ref_clk),
        .srst    (srst),
        .start   (tmr_start),
        .count   (tmr_count),
        .busy    (tmr_busy),
        .done    (tmr_done)
    );

    // Operation sequencer and flash command port
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_reg      <= ST_BOOT;
            rd_ph_reg   <= 1'b0;
            op_data_reg <= 8'h00;
            fl_o        <= '0;
        end else begin
            fl_o.rd    <= 1'b0;
            fl_o.prog  <= 1'b0;
            fl_o.erase <= 1'b0;
            case (st_reg)
                ST_BOOT: begin
                    fl_o.rd   <= 1'b1;
                    fl_o.addr <= LOCK_BYTE_ADDR[FLASH_AW-1:0];
                    rd_ph_reg <= 1'b0;
                    st_reg    <= ST_BOOTW;
                end
                ST_BOOTW, ST_CODE: begin
                    rd_ph_reg <= !rd_ph_reg;
                    if (rd_ph_reg) begin
                        st_reg <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    rd_ph_reg <= 1'b0;
                    if (op_go) begin
                        fl_o.addr <= st_i.addr[FLASH_AW-1:0];
                        if (see_reg) begin
                            fl_o.erase <= 1'b1;
                            st_reg     <= ST_ERASE;
                        end else begin
                            fl_o.rd     <= 1'b1;
                            op_data_reg <= st_i.data;
                            st_reg      <= ST_PREAD;
                        end
                    end else if (cd_take && cd_ok) begin
                        fl_o.rd   <= 1'b1;
                        fl_o.addr <= cd_i.addr[FLASH_AW-1:0];
                        st_reg    <= ST_CODE;
                    end
                end
                ST_PREAD: begin
                    rd_ph_reg <= !rd_ph_reg;
                    if (rd_ph_reg) begin
                        fl_o.prog  <= 1'b1;
                        fl_o.wdata <= fl_rdata_i & op_data_reg;
                        st_reg     <= ST_PROG;
                    end
                end
                ST_PROG, ST_ERASE: begin
                    if (tmr_done) begin
                        st_reg <= ST_IDLE;
                    end
                end
                default: begin
                    st_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Processor stall from boot and accepted op until completion
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            stall_o <= 1'b1;
        end else if (op_go) begin
            stall_o <= 1'b1;
        end else if (op_end || (rd_last && (st_reg == ST_BOOTW))) begin
            stall_o <= 1'b0;
        end
    end

    // Store answers and data RAM write routing
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_ack_o <= 1'b0;
            ram_wr_o <= '0;
        end else begin
            st_ack_o     <= 1'b0;
            ram_wr_o.req <= 1'b0;
            if (st_take && !swe_reg) begin
                ram_wr_o <= '{req: 1'b1, addr: st_i.addr,
                              data: st_i.data};
                st_ack_o <= 1'b1;
            end else if (flash_st && !op_go) begin
                st_ack_o <= 1'b1;
            end else if (op_end) begin
                st_ack_o <= 1'b1;
            end
        end
    end

    // Code-space read answers
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cd_ack_o  <= 1'b0;
            cd_data_o <= 8'h00;
        end else begin
            cd_ack_o <= 1'b0;
            if (cd_take && !cd_ok) begin
                cd_ack_o  <= 1'b1;
                cd_data_o <= ERASED_BYTE;
            end else if (rd_last && (st_reg == ST_CODE)) begin
                cd_ack_o  <= 1'b1;
                cd_data_o <= fl_rdata_i;
            end
        end
    end

    // Data loads always go to data RAM
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ram_rd_o <= '0;
        end else begin
            ram_rd_o <= ld_i;
        end
    end

    // Flash error reset request pulse
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ferr_rst_o <= 1'b0;
        end else begin
            ferr_rst_o <= sec_fail;
        end
    end

    // Lock byte copy, loaded at boot, tracks writes to it
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            lock_reg <= LOCK_RESET;
        end else if (rd_last && (st_reg == ST_BOOTW)) begin
            lock_reg <= fl_rdata_i;
        end else if (rd_last && (st_reg == ST_PREAD) &&
                     (fl_o.addr == LOCK_BYTE_ADDR[FLASH_AW-1:0])) begin
            lock_reg <= fl_rdata_i & op_data_reg;
        end
    end

    // Key sequence state; disabled state holds until reset
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            key_reg <= KY_LOCKED;
        end else if (key_reg == KY_DEAD) begin
            key_reg <= KY_DEAD;
        end else if (bad_try) begin
            key_reg <= KY_DEAD;
        end else if (key_wr) begin
            case (key_reg)
                KY_LOCKED: begin
                    key_reg <= (wb_dat_i[7:0] == KEY_FIRST) ?
                               KY_FIRST : KY_DEAD;
                end
                KY_FIRST: begin
                    key_reg <= (wb_dat_i[7:0] == KEY_SECOND) ?
                               KY_OPEN : KY_DEAD;
                end
                default: begin
                    key_reg <= KY_DEAD;
                end
            endcase
        end else if (op_go) begin
            key_reg <= KY_LOCKED;
        end
    end

    // Store control bits, changed only by software
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            swe_reg <= CTRL_RESET;
            see_reg <= CTRL_RESET;
        end else if (wb_wr && (wb_adr_i == REG_CTRL_OFS)) begin
            swe_reg <= wb_dat_i[CTRL_SWE_BIT];
            see_reg <= wb_dat_i[CTRL_SEE_BIT];
        end
    end

    // Two-bit lock state code
    always_comb begin
        case (key_reg)
            KY_LOCKED: key_code = KS_LOCKED;
            KY_FIRST:  key_code = KS_FIRST;
            KY_OPEN:   key_code = KS_OPEN;
            default:   key_code = KS_DEAD;
        endcase
    end

    // Register read multiplexer, unmapped reads zero
    always_comb begin
        rd_word = 32'h0000_0000;
        case (wb_adr_i)
            REG_KEY_OFS: begin
                rd_word[1:0] = key_code;
            end
            REG_CTRL_OFS: begin
                rd_word[CTRL_SWE_BIT] = swe_reg;
                rd_word[CTRL_SEE_BIT] = see_reg;
            end
            REG_STAT_OFS: begin
                rd_word[7:0]          = lock_reg;
                rd_word[STAT_BUSY_BIT] = tmr_busy;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    // Wishbone answer one cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_hit;
            if (wb_hit && !wb_we_i) begin
                wb_dat_o <= rd_word;
            end
        end
    end

endmodule // fwg_top

// ===== hdl/fwg_pkg.sv
package fwg_pkg;

    // Clock and operation timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int WRITE_TIME_NS = 40000;
    localparam int ERASE_TIME_NS = 10000000;
    localparam int WRITE_CYCLES  =
        (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ERASE_CYCLES  =
        (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W         = 20;

    // Key codes and flash values
    localparam logic [7:0]  KEY_FIRST      = 8'hA5;
    localparam logic [7:0]  KEY_SECOND     = 8'hF1;
    localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
    localparam logic [7:0]  LOCK_RESET     = 8'h00;
    localparam logic [15:0] USER_TOP       = 16'h3DFF;
    localparam logic [15:0] LOCK_BYTE_ADDR = 16'h3DFF;
    localparam logic [4:0]  LOCK_PAGE      = 5'h1E;
    localparam int          PAGE_LSB       = 9;
    localparam int          PAGE_MSB       = 13;
    localparam int          FLASH_AW       = 14;

    // Register byte offsets on the bus
    localparam logic [3:0]  REG_KEY_OFS    = 4'h0;
    localparam logic [3:0]  REG_CTRL_OFS   = 4'h4;
    localparam logic [3:0]  REG_STAT_OFS   = 4'h8;

    // Field positions and reset values
    localparam int          CTRL_SWE_BIT   = 0;
    localparam int          CTRL_SEE_BIT   = 1;
    localparam int          STAT_BUSY_BIT  = 8;
    localparam logic        CTRL_RESET     = 1'h0;

    // Lock state codes as read back
    localparam logic [1:0]  KS_LOCKED      = 2'h0;
    localparam logic [1:0]  KS_FIRST       = 2'h1;
    localparam logic [1:0]  KS_OPEN        = 2'h2;
    localparam logic [1:0]  KS_DEAD        = 2'h3;

    typedef enum logic [3:0] {
        KY_LOCKED = 4'b0001,
        KY_FIRST  = 4'b0010,
        KY_OPEN   = 4'b0100,
        KY_DEAD   = 4'b1000
    } fwg_key_t;

    typedef enum logic [6:0] {
        ST_BOOT  = 7'b0000001,
        ST_BOOTW = 7'b0000010,
        ST_IDLE  = 7'b0000100,
        ST_CODE  = 7'b0001000,
        ST_PREAD = 7'b0010000,
        ST_PROG  = 7'b0100000,
        ST_ERASE = 7'b1000000
    } fwg_seq_t;

    // Store request, also used for data RAM writes
    typedef struct packed {
        logic        req;
        logic [15:0] addr;
        logic [7:0]  data;
    } fwg_store_t;

    // Address-only request: code fetch, data load
    typedef struct packed {
        logic        req;
        logic [15:0] addr;
    } fwg_fetch_t;

    // Command to the flash array
    typedef struct packed {
        logic                rd;
        logic                prog;
        logic                erase;
        logic [FLASH_AW-1:0] addr;
        logic [7:0]          wdata;
    } fwg_flash_cmd_t;

endpackage

// ===== hdl/fwg_cycle_timer.sv
module fwg_cycle_timer
    import fwg_pkg::*;
#(
    parameter int W = TMR_W                 // Counter width
) (
    input  wire logic         ref_clk,      // System clock
    input  wire logic         srst,         // Sync reset
    input  wire logic         start,        // Load and run
    input  wire logic [W-1:0] count,        // Cycles to run
    output logic              busy,         // Counting
    output logic              done          // End pulse
);

    logic [W-1:0] cnt_reg;

    // Down counter, done one cycle after the last count
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cnt_reg <= '0;
            busy    <= 1'b0;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                cnt_reg <= count;
                busy    <= 1'b1;
            end else if (busy) begin
                if (cnt_reg <= W'(1)) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                cnt_reg <= cnt_reg - W'(1);
            end
        end
    end

endmodule // fwg_cycle_timer

// ===== bench/fwg_flash_model.sv
module fwg_flash_model
    import fwg_pkg::*;
(
    input  wire logic       ref_clk,  // System clock
    input  fwg_flash_cmd_t  fl_i,     // Command from the guard
    output logic      [7:0] rdata_o   // Array read byte
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:(2**FLASH_AW)-1];
    logic [7:0] q_reg = 8'h00;
    logic       vld_reg = 1'b0;
    // Blank array, lock byte at top of user space reads erased
    initial foreach (mem[i]) mem[i] = ERASED_BYTE;
    // Sync read, byte program as given, whole-page erase
    always @(posedge ref_clk) begin
        vld_reg <= fl_i.rd;
        if (fl_i.rd) q_reg <= mem[fl_i.addr];
        if (fl_i.prog) mem[fl_i.addr] <= fl_i.wdata;
        if (fl_i.erase) for (int i = 0; i < 512; i++)
            mem[{fl_i.addr[13:9], 9'(i)}] <= ERASED_BYTE;
    end
    // Data shows only in its valid cycle
    assign rdata_o = vld_reg ? q_reg : ~q_reg;
endmodule // fwg_flash_model

// ===== bench/fwg_top_asserts.sv
module fwg_top_asserts
    import fwg_pkg::*;
#(
    parameter int unsigned ERASE_CYCLES_P = 20 // Erase cycles
) (
    input  wire logic        ref_clk,    // System clock
    input  wire logic        srst,       // Sync reset
    input  wire logic        wb_cyc_i,   // Bus cycle
    input  wire logic        wb_stb_i,   // Bus strobe
    input  wire logic        wb_we_i,    // Bus write
    input  wire logic [3:0]  wb_adr_i,   // Bus address
    input  wire logic [31:0] wb_dat_o,   // Bus read data
    input  wire logic        wb_ack_o,   // Bus acknowledge
    input  fwg_store_t       st_i,       // Processor store
    input  wire logic        st_ack_o,   // Store done
    input  fwg_fetch_t       cd_i,       // Code read
    input  wire logic        cd_ack_o,   // Code read done
    input  wire logic [7:0]  cd_data_o,  // Code read byte
    input  fwg_fetch_t       ld_i,       // Data load
    input  wire logic        stall_o,    // Processor hold
    input  fwg_store_t       ram_wr_o,   // Data RAM write
    input  fwg_fetch_t       ram_rd_o,   // Data RAM read
    input  fwg_flash_cmd_t   fl_o,       // Flash command
    input  wire logic [7:0]  fl_rdata_i, // Flash read byte
    input  wire logic        ferr_rst_o  // Flash error reset
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int E_LO = ERASE_CYCLES_P;
    localparam int E_HI = ERASE_CYCLES_P + 3;
    logic [11:0] pcnt_reg;
    logic        prun_reg;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    // Cycles since the program pulse
    always_ff @(posedge ref_clk) begin
        if (srst) prun_reg <= 1'b0;
        else if (fl_o.prog) prun_reg <= 1'b1;
        else if (st_ack_o) prun_reg <= 1'b0;
    end
    always_ff @(posedge ref_clk) begin
        pcnt_reg <= fl_o.prog ? 12'h000 : pcnt_reg + 12'h001;
    end
    a_wb_answer: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus ack late");
    a_key_state: assert property (
        wb_ack_o && !wb_we_i && wb_adr_i == REG_KEY_OFS |->
        wb_dat_o[31:2] == '0) else $error("key read too wide");
    a_load_ram: assert property (
        !srst && ld_i.req |=>
        ram_rd_o.req && ram_rd_o.addr == $past(ld_i.addr))
        else $error("load not sent to RAM");
    a_prog_clear: assert property (
        fl_o.prog |-> (fl_o.wdata & ~$past(fl_rdata_i)) == 8'h00)
        else $error("program sets a bit");
    a_prog_time: assert property (
        prun_reg && st_ack_o |-> pcnt_reg >= WRITE_CYCLES - 2 &&
        pcnt_reg <= WRITE_CYCLES + 3) else $error("program time wrong");
    a_prog_stall: assert property (
        prun_reg && !st_ack_o |-> stall_o && pcnt_reg <= WRITE_CYCLES + 3)
        else $error("program stall wrong");
    a_erase_time: assert property (
        fl_o.erase |-> ##[E_LO:E_HI] st_ack_o)
        else $error("erase time wrong");
    a_erase_stall: assert property (
        fl_o.erase |-> (stall_o && !st_ack_o)[*8])
        else $error("no stall during erase");
    a_reserved: assert property (
        cd_ack_o && cd_i.addr > USER_TOP |->
        ferr_rst_o && cd_data_o == ERASED_BYTE)
        else $error("reserved read not refused");
    a_ram_store: assert property (
        ram_wr_o.req |-> st_ack_o && !fl_o.prog &&
        ram_wr_o.addr == st_i.addr && ram_wr_o.data == st_i.data)
        else $error("RAM write wrong");
    a_one_byte: assert property (
        fl_o.prog |-> st_i.req && fl_o.addr == st_i.addr[13:0])
        else $error("program addr wrong");
    a_erase_page: assert property (
        fl_o.erase |-> st_i.req && fl_o.addr[13:9] == st_i.addr[13:9])
        else $error("erase page mismatch");
endmodule // fwg_top_asserts

bind fwg_top fwg_top_asserts #(
    .ERASE_CYCLES_P(ERASE_CYCLES_P)
) u_fwg_top_asserts (
    .ref_clk(ref_clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .st_i(st_i),
    .st_ack_o(st_ack_o), .cd_i(cd_i), .cd_ack_o(cd_ack_o),
    .cd_data_o(cd_data_o), .ld_i(ld_i), .stall_o(stall_o),
    .ram_wr_o(ram_wr_o), .ram_rd_o(ram_rd_o), .fl_o(fl_o),
    .fl_rdata_i(fl_rdata_i), .ferr_rst_o(ferr_rst_o)
);

// ===== bench/testbench.sv
module testbench
    import fwg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int EC = 20;
    logic           ref_clk = 1'b0;
    logic           srst = 1'b1;
    logic           wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [3:0]     wb_adr_i, wb_sel_i;
    logic [31:0]    wb_dat_i, wb_dat_o, rd;
    logic           st_ack_o, cd_ack_o, stall_o, ferr_rst_o;
    logic [7:0]     cd_data_o, fl_rdata_i, cb, d, d2;
    logic [15:0]    exec_pc_i, a;
    fwg_store_t     st_i, ram_wr_o;
    fwg_fetch_t     cd_i, ld_i, ram_rd_o;
    fwg_flash_cmd_t fl_o;
    int             err_count = 0;
    int             n_tests = 0;
    int             cyc_n = 0, ferr_n = 0;

    fwg_top #(.ERASE_CYCLES_P(EC)) u_fwg_top (
        .ref_clk(ref_clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .st_i(st_i), .st_ack_o(st_ack_o),
        .cd_i(cd_i), .cd_ack_o(cd_ack_o), .cd_data_o(cd_data_o),
        .ld_i(ld_i), .exec_pc_i(exec_pc_i), .stall_o(stall_o),
        .ram_wr_o(ram_wr_o), .ram_rd_o(ram_rd_o), .fl_o(fl_o),
        .fl_rdata_i(fl_rdata_i), .ferr_rst_o(ferr_rst_o));
    fwg_flash_model u_fwg_flash_model (
        .ref_clk(ref_clk), .fl_i(fl_o), .rdata_o(fl_rdata_i));

    // Free-running clock
    initial forever #10 ref_clk = ~ref_clk;

    // Random loads, error-reset count, run ceiling
    always @(posedge ref_clk) begin
        cyc_n <= cyc_n + 1;
        ld_i <= 17'($urandom);
        if (ferr_rst_o === 1'b1) ferr_n <= ferr_n + 1;
        if (cyc_n == 30000) begin
            err_count++;
            close_out();
        end
    end

    function automatic logic [7:0] exp_prog(logic [7:0] o, logic [7:0] n);
        return o & n;
    endfunction
    function automatic logic [15:0] pg_base(logic [15:0] x);
        return {x[15:9], 9'h000};
    endfunction

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One classic bus cycle, held until ack
    task automatic wbc(logic we, logic [3:0] adr, logic [31:0] dat);
        @(posedge ref_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <=
            {2'b11, we, adr, {3'h7, ~dat[31]}, dat};
        do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task automatic rchk(string nm, logic [3:0] adr, logic [31:0] exp);
        wbc(1'b0, adr, 32'h0000_0000);
        check(nm, rd, exp);
    endtask
    task automatic unlock();
        wbc(1'b1, REG_KEY_OFS, 32'(KEY_FIRST));
        wbc(1'b1, REG_KEY_OFS, 32'(KEY_SECOND));
    endtask
    task automatic store(logic [15:0] ad, logic [7:0] dt);
        @(posedge ref_clk);
        st_i <= {1'b1, ad, dt};
        do @(posedge ref_clk); while (st_ack_o !== 1'b1);
        st_i <= {1'b0, ~ad, ~dt};
    endtask
    task automatic cread(logic [15:0] ad);
        @(posedge ref_clk);
        cd_i <= {1'b1, ad};
        do @(posedge ref_clk); while (cd_ack_o !== 1'b1);
        cb = cd_data_o;
        cd_i <= {1'b0, ~ad};
        @(posedge ref_clk);
    endtask
    task automatic prog(logic [15:0] ad, logic [7:0] dt);
        unlock();
        wbc(1'b1, REG_CTRL_OFS, 32'h0000_0001);
        store(ad, dt);
        wbc(1'b1, REG_CTRL_OFS, 32'h0000_0000);
    endtask
    task automatic do_reset();
        srst <= 1'b1;
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        do @(posedge ref_clk); while (stall_o !== 1'b0);
    endtask

    // Main sequence
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        {st_i, cd_i} = '0;
        exec_pc_i = 16'h1000;
        void'($urandom(65));
        do_reset();
        rchk("key", REG_KEY_OFS, 32'h0000_0000);
        rchk("ctrl", REG_CTRL_OFS, 32'h0000_0000);
        rchk("stat", REG_STAT_OFS, 32'h0000_00FF);
        rchk("unmapped", 4'hC, 32'h0000_0000);
        wbc(1'b1, REG_CTRL_OFS, 32'h8000_0001);
        rchk("sel", REG_CTRL_OFS, 32'h0000_0000);
        a = 16'h0200 | 16'($urandom & 32'h0DFF);
        d = 8'($urandom);
        d2 = 8'($urandom);
        // Key steps, then one byte program
        wbc(1'b1, REG_KEY_OFS, 32'(KEY_FIRST));
        rchk("key", REG_KEY_OFS, 32'h0000_0001);
        wbc(1'b1, REG_KEY_OFS, 32'(KEY_SECOND));
        rchk("key", REG_KEY_OFS, 32'h0000_0002);
        wbc(1'b1, REG_CTRL_OFS, 32'h0000_0001);
        store(a, d);
        rchk("key", REG_KEY_OFS, 32'h0000_0000);
        rchk("ctrl", REG_CTRL_OFS, 32'h0000_0001);
        wbc(1'b1, REG_CTRL_OFS, 32'h0000_0000);
        cread(a);
        check("byte", 32'(cb), 32'(d));
        cread(a + 16'h0001);
        check("next", 32'(cb), 32'(ERASED_BYTE));
        prog(a, d2);
        cread(a);
        check("reprog", 32'(cb), 32'(exp_prog(d, d2)));
        // Erase enable alone is a plain data RAM store
        wbc(1'b1, REG_CTRL_OFS, 32'h0000_0002);
        store(a, 8'h00);
        cread(a);
        check("see only", 32'(cb), 32'(exp_prog(d, d2)));
        rchk("key", REG_KEY_OFS, 32'h0000_0000);
        // Page erase, neighbour page kept
        prog(pg_base(a) + 16'h0200, 8'h5A);
        unlock();
        wbc(1'b1, REG_CTRL_OFS, 32'h0000_0002);
        wbc(1'b1, REG_CTRL_OFS, 32'h0000_0003);
        store(a, 8'($urandom));
        wbc(1'b1, REG_CTRL_OFS, 32'h0000_0002);
        wbc(1'b1, REG_CTRL_OFS, 32'h0000_0000);
        for (int i = 0; i < 3; i++) begin
            cread(i == 0 ? a : pg_base(a) + 16'(i - 1) * 16'h01FF);
            check("erased", 32'(cb), 32'(ERASED_BYTE));
        end
        cread(pg_base(a) + 16'h0200);
        check("kept", 32'(cb), 32'h0000_005A);
        // Reserved region refused with error reset
        prog(16'h3E00 | 16'($urandom & 32'h01FF), d);
        check("ferr", ferr_n, 1);
        cread(16'h3F00);
        check("ferr", ferr_n, 2);
        // Lock byte 0xFE: page 0 and lock page locked
        do_reset();
        prog(LOCK_BYTE_ADDR, 8'hFE);
        rchk("stat", REG_STAT_OFS, 32'h0000_00FE);
        cread(16'h0100);
        check("ferr", ferr_n, 3);
        cread(16'h0200);
        check("ferr", ferr_n, 3);
        cread(16'h3C10);
        check("ferr", ferr_n, 4);
        exec_pc_i <= 16'h0080;
        cread(16'h0100);
        check("ferr", ferr_n, 4);
        exec_pc_i <= 16'h1000;
        // Misuse locks out until reset
        wbc(1'b1, REG_CTRL_OFS, 32'h0000_0001);
        store(16'h0400, 8'h00);
        rchk("key", REG_KEY_OFS, 32'h0000_0003);
        wbc(1'b1, REG_KEY_OFS, 32'(KEY_FIRST));
        rchk("key", REG_KEY_OFS, 32'h0000_0003);
        for (int i = 0; i < 3; i++) begin
            do_reset();
            d = i == 0 ? (8'($urandom) | 8'h02) : KEY_SECOND;
            if (i == 2) wbc(1'b1, REG_KEY_OFS, 32'(KEY_FIRST));
            wbc(1'b1, REG_KEY_OFS, 32'(i == 2 ? KEY_FIRST : d));
            rchk("key", REG_KEY_OFS, 32'h0000_0003);
        end
        close_out();
    end
endmodule // testbench
